//--- hdl/irq_ctrl_pkg.sv
// Purpose: shared constants for the two-level interrupt controller
// Assumes: byte-wide special-register port inside the processor core
// Notes:   offsets are register addresses in the special-register space
package irq_ctrl_pkg;
	localparam int          NUM_SRC       = 12;    // interrupt sources
	localparam int          NUM_HW_CLR    = 4;     // sources 0..3 auto-clear on vector
	localparam int          MAIN_SRC      = 6;     // sources held in the main registers
	localparam logic [7:0]  ADDR_EN_MAIN  = 8'ha8; // irq_enable_main
	localparam logic [7:0]  ADDR_PRI_MAIN = 8'hb8; // irq_priority_main
	localparam logic [7:0]  ADDR_EXT_CFG  = 8'he4; // ext_input_irq_config
	localparam logic [7:0]  ADDR_EN_EXT   = 8'he6; // irq_enable_extended
	localparam logic [7:0]  ADDR_PRI_EXT  = 8'hf6; // irq_priority_extended
	localparam int          GLOBAL_EN_BIT = 7;     // global_irq_enable position
	localparam logic [7:0]  REG_RESET     = 8'h00; // every register after reset
	localparam logic [15:0] VEC_BASE      = 16'h0003; // vector of source 0
	localparam logic [15:0] VEC_STEP      = 16'h0008; // spacing of vectors
endpackage

//--- hdl/two_level_irq_controller.sv
// Purpose: twelve-source, two-level interrupt controller for a small core
// Assumes: core pulses instr_done_i at each instruction end, return_from_interrupt_done_i
//          when a return_from_interrupt completes, and starts long_call on long_call_o
// Notes:   read data is registered, one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module two_level_irq_controller #(
	parameter int NSRC = irq_ctrl_pkg::NUM_SRC // source count, fixed by the register map
) (
	input  wire logic             clk_i,        // system clock, 200 MHz
	input  wire logic             rst_i,        // async reset, active high
	input  wire logic [7:0]       sfr_addr_i,   // special-register address
	input  wire logic             sfr_wr_i,     // write strobe
	input  wire logic             sfr_rd_i,     // read strobe
	input  wire logic [7:0]       sfr_wdata_i,  // write data
	output logic      [7:0]       sfr_rdata_o,  // registered read data
	output logic                  sfr_hit_o,    // read data belongs to this block
	input  wire logic [NSRC-1:0]  trig_i,       // peripheral trigger pulses
	input  wire logic [NSRC-1:0]  sw_set_i,     // software writes 1 to a flag
	input  wire logic [NSRC-1:0]  sw_clr_i,     // software writes 0 to a flag
	output logic      [NSRC-1:0]  pending_o,    // pending flags
	input  wire logic             instr_done_i, // current instruction completes
	input  wire logic             return_from_interrupt_done_i,  // return_from_interrupt completes
	output logic                  long_call_o,      // start long_call, one-cycle pulse
	output logic      [15:0]      vector_o,     // service_routine address
	output logic      [3:0]       src_o,        // source being entered
	output logic      [7:0]       ext_cfg_o,    // ext_input_irq_config contents
	output logic                  active_hi_o,  // high-level routine running
	output logic                  active_lo_o   // low-level routine running
);
	if (NSRC != irq_ctrl_pkg::NUM_SRC) begin : g_nsrc_check
		$error("register map serves exactly twelve sources");
	end

	logic [7:0]      en_main_reg;  // irq_enable_main
	logic [7:0]      pri_main_reg; // irq_priority_main
	logic [7:0]      en_ext_reg;   // irq_enable_extended
	logic [7:0]      pri_ext_reg;  // irq_priority_extended
	logic [7:0]      ext_cfg_reg;  // ext_input_irq_config
	logic [NSRC-1:0] pend_reg;     // pending flags
	logic [NSRC-1:0] src_en;       // per-source enable
	logic [NSRC-1:0] src_hi;       // per-source priority
	logic [NSRC-1:0] req_mask;     // enabled pending flags
	logic            req_reg;      // sampled request valid
	logic [3:0]      req_src_reg;  // sampled winning source
	logic            req_hi_reg;   // sampled winner is high level
	logic            hold_reg;     // cycle right after a return
	logic            act_hi_reg;   // high routine in service
	logic            act_lo_reg;   // low routine in service
	logic            long_call_reg;    // long_call pulse
	logic [15:0]     vec_reg;      // vector register
	logic [3:0]      src_reg;      // entered source
	logic [NSRC-1:0] auto_clr;     // flags cleared by vectoring
	logic            take;         // vector at this boundary
	logic            pick_v;       // a qualifying request exists
	logic [3:0]      pick_s;       // its source
	logic            pick_h;       // its level

	// fixed vector per source
	function automatic logic [15:0] vec_of(input logic [3:0] s);
		vec_of = irq_ctrl_pkg::VEC_BASE + irq_ctrl_pkg::VEC_STEP * {12'h000, s};
	endfunction

	// register writes, one always per register group
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_main_reg  <= irq_ctrl_pkg::REG_RESET;
			en_ext_reg   <= irq_ctrl_pkg::REG_RESET;
		end else if (sfr_wr_i) begin
			if (sfr_addr_i == irq_ctrl_pkg::ADDR_EN_MAIN)
				en_main_reg <= sfr_wdata_i;
			if (sfr_addr_i == irq_ctrl_pkg::ADDR_EN_EXT)
				en_ext_reg <= sfr_wdata_i;
		end
	end

	// priority and configuration registers, low level after reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pri_main_reg <= irq_ctrl_pkg::REG_RESET;
			pri_ext_reg  <= irq_ctrl_pkg::REG_RESET;
			ext_cfg_reg  <= irq_ctrl_pkg::REG_RESET;
		end else if (sfr_wr_i) begin
			if (sfr_addr_i == irq_ctrl_pkg::ADDR_PRI_MAIN)
				pri_main_reg <= sfr_wdata_i;
			if (sfr_addr_i == irq_ctrl_pkg::ADDR_PRI_EXT)
				pri_ext_reg <= sfr_wdata_i;
			if (sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_CFG)
				ext_cfg_reg <= sfr_wdata_i;
		end
	end

	// registered read port
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sfr_rdata_o <= 8'h00;
			sfr_hit_o   <= 1'b0;
		end else begin
			sfr_hit_o   <= 1'b0;
			sfr_rdata_o <= 8'h00;
			if (sfr_rd_i) begin
				sfr_hit_o <= 1'b1;
				unique case (sfr_addr_i)
					irq_ctrl_pkg::ADDR_EN_MAIN:  sfr_rdata_o <= en_main_reg;
					irq_ctrl_pkg::ADDR_PRI_MAIN: sfr_rdata_o <= pri_main_reg;
					irq_ctrl_pkg::ADDR_EXT_CFG:  sfr_rdata_o <= ext_cfg_reg;
					irq_ctrl_pkg::ADDR_EN_EXT:   sfr_rdata_o <= en_ext_reg;
					irq_ctrl_pkg::ADDR_PRI_EXT:  sfr_rdata_o <= pri_ext_reg;
					default:                     sfr_hit_o   <= 1'b0; // not ours
				endcase
			end
		end
	end

	// map register bits onto sources, gate with global enable
	always_comb begin
		src_en = {en_ext_reg[5:0], en_main_reg[5:0]};
		src_hi = {pri_ext_reg[5:0], pri_main_reg[5:0]};
		req_mask = en_main_reg[irq_ctrl_pkg::GLOBAL_EN_BIT] ? (pend_reg & src_en)
		                                                    : '0;
	end

	// flags that clear themselves when their routine is entered
	always_comb begin
		auto_clr = '0;
		if (take && req_src_reg < 4'(irq_ctrl_pkg::NUM_HW_CLR))
			auto_clr[req_src_reg] = 1'b1;
	end

	// per-flag set/clear; a set always beats a clear
	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_flag
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i)
					pend_reg[g] <= 1'b0;
				else if (trig_i[g] || sw_set_i[g])
					pend_reg[g] <= 1'b1;
				else if (sw_clr_i[g] || auto_clr[g])
					pend_reg[g] <= 1'b0;
			end
		end
	endgenerate

	// arbitration: high beats low, lower index wins a tie
	always_comb begin
		pick_v = 1'b0;
		pick_s = 4'h0;
		pick_h = 1'b0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (req_mask[i] && src_hi[i] && !act_hi_reg) begin
				pick_v = 1'b1;
				pick_s = 4'(i);
				pick_h = 1'b1;
			end
		end
		if (!pick_v) begin
			for (int i = NSRC - 1; i >= 0; i--) begin
				if (req_mask[i] && !src_hi[i] && !act_hi_reg && !act_lo_reg) begin
					pick_v = 1'b1;
					pick_s = 4'(i);
				end
			end
		end
	end

	// request sampled every clock; stale enables thus linger one cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_reg     <= 1'b0;
			req_src_reg <= 4'h0;
			req_hi_reg  <= 1'b0;
		end else begin
			req_reg     <= pick_v && !take;
			req_src_reg <= pick_s;
			req_hi_reg  <= pick_h;
		end
	end

	// vector only at an instruction boundary, not right after a return
	assign take = req_reg && instr_done_i && !hold_reg;

	// hold only for the cycle after a return; the instruction that
	// follows the return may then end with a long_call
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			hold_reg <= 1'b0; // idle after reset
		else if (return_from_interrupt_done_i)
			hold_reg <= 1'b1;
		else
			hold_reg <= 1'b0;
	end

	// in-service levels: set on entry, highest cleared on return
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			act_hi_reg <= 1'b0;
			act_lo_reg <= 1'b0;
		end else if (take) begin
			if (req_hi_reg)
				act_hi_reg <= 1'b1;
			else
				act_lo_reg <= 1'b1;
		end else if (return_from_interrupt_done_i) begin
			if (act_hi_reg)
				act_hi_reg <= 1'b0;
			else
				act_lo_reg <= 1'b0;
		end
	end

	// long_call request and its target
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			long_call_reg <= 1'b0;
			vec_reg   <= 16'h0000;
			src_reg   <= 4'h0;
		end else begin
			long_call_reg <= take;
			if (take) begin
				vec_reg <= vec_of(req_src_reg);
				src_reg <= req_src_reg;
			end
		end
	end

	assign pending_o   = pend_reg;
	assign long_call_o     = long_call_reg;
	assign vector_o    = vec_reg;
	assign src_o       = src_reg;
	assign ext_cfg_o   = ext_cfg_reg;
	assign active_hi_o = act_hi_reg;
	assign active_lo_o = act_lo_reg;

	// checks
	a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		trig_i[4] |=> pend_reg[4])
		else $error("trigger did not set pending flag");
	a_global_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!en_main_reg[7] |-> req_mask == '0)
		else $error("request passed with global enable off");
	a_disabled_src: assert property (@(posedge clk_i) disable iff (rst_i)
		!src_en[0] |-> !req_mask[0])
		else $error("disabled source raised request");
	a_call_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> long_call_o && vector_o == vec_of($past(req_src_reg)))
		else $error("long_call missing or wrong vector");
	a_call_only_take: assert property (@(posedge clk_i) disable iff (rst_i)
		long_call_o |-> $past(instr_done_i) && $past(req_reg))
		else $error("long_call without boundary");
	a_hold_return_from_interrupt: assert property (@(posedge clk_i) disable iff (rst_i)
		return_from_interrupt_done_i |=> !take)
		else $error("vectored right after return");
	a_hi_nopreempt: assert property (@(posedge clk_i) disable iff (rst_i)
		act_hi_reg && !return_from_interrupt_done_i |=> !take)
		else $error("high routine was preempted");
	a_auto_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		take && req_src_reg == 4'h1 && !trig_i[1] && !sw_set_i[1] |=> !pend_reg[1])
		else $error("hardware-cleared flag stayed set");
	a_keep_soft: assert property (@(posedge clk_i) disable iff (rst_i)
		take && req_src_reg == 4'h6 && !sw_clr_i[6] |=> pend_reg[6])
		else $error("software-cleared flag vanished");
	a_sample_req: assert property (@(posedge clk_i) disable iff (rst_i)
		pick_v && !take |=> req_reg)
		else $error("request not sampled next cycle");
	// return bookkeeping and tie order
	a_ret_level: assert property (@(posedge clk_i) disable iff (rst_i)
		return_from_interrupt_done_i && !take && act_hi_reg |=> !act_hi_reg && act_lo_reg == $past(act_lo_reg))
		else $error("return did not drop the high level");
	a_low_index: assert property (@(posedge clk_i) disable iff (rst_i)
		pick_v && !pick_h && req_mask[0] && !src_hi[0] |-> pick_s == 4'h0)
		else $error("low tie not won by lowest source");

	c_low_entry:  cover property (@(posedge clk_i) disable iff (rst_i) take && !req_hi_reg);
	c_preempt:    cover property (@(posedge clk_i) disable iff (rst_i) take && act_lo_reg);
	c_reentry:    cover property (@(posedge clk_i) disable iff (rst_i)
		return_from_interrupt_done_i ##[1:20] take);
	c_sw_trigger: cover property (@(posedge clk_i) disable iff (rst_i) sw_set_i[8] ##[1:10] take);
	c_high_entry: cover property (@(posedge clk_i) disable iff (rst_i) take && req_hi_reg);
endmodule
`default_nettype wire

//--- tb/core_model.sv
// Purpose: behavioural processor core, the controller's far side
// Assumes: one instruction ends every gap_i+1 cycles
// Notes:   a requested return replaces the next instruction end
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic       clk_i,        // system clock
	input  wire logic       rst_i,        // async reset, active high
	input  wire logic       long_call_i,      // long_call starts
	input  wire logic       return_from_interrupt_req_i,   // firmware reaches its return
	input  wire logic [3:0] gap_i,        // instruction length, prompt or slow
	output logic            instr_done_o, // instruction completes
	output logic            return_from_interrupt_done_o   // return_from_interrupt completes
);
	logic [3:0] cnt_reg;  // cycles into current instruction
	logic       ret_reg;  // return waiting to execute
	// instruction sequencer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg      <= 4'h0;
			ret_reg      <= 1'b0;
			instr_done_o <= 1'b0;
			return_from_interrupt_done_o  <= 1'b0;
		end else begin
			instr_done_o <= 1'b0;
			return_from_interrupt_done_o  <= 1'b0;
			if (long_call_i) begin // long_call restarts instruction timing
				cnt_reg <= 4'h0;
			end else if (cnt_reg >= gap_i) begin
				cnt_reg <= 4'h0;
				if (ret_reg) begin // routine ends with a return
					return_from_interrupt_done_o <= 1'b1;
					ret_reg     <= 1'b0;
				end else begin
					instr_done_o <= 1'b1;
				end
			end else begin
				cnt_reg <= cnt_reg + 4'h1;
			end
			if (return_from_interrupt_req_i) begin
				ret_reg <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: core_model drives instruction and return timing
// Notes:   all stimulus lands 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, hit, long_call;
	logic        rq = 1'b0, idone, rdone, ahi, alo;
	logic [7:0]  addr = 8'h00, wd = 8'h00, rdat, cfg;
	logic [11:0] trig = '0, sset = '0, sclr = '0, pend;
	logic [15:0] vec;
	logic [3:0]  src, gap = 4'h2;
	int          fails = 0, tests_run = 0, nsr = 0, at_call = 0, i;
	logic [7:0]  regs [5] = '{8'ha8, 8'hb8, 8'he4, 8'he6, 8'hf6}; // mapped addresses
	always #2.5 clk = ~clk; // 200 MHz
	two_level_irq_controller dut (.clk_i(clk), .rst_i(rst), .sfr_addr_i(addr), .sfr_wr_i(wr),
		.sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdat), .sfr_hit_o(hit), .trig_i(trig),
		.sw_set_i(sset), .sw_clr_i(sclr), .pending_o(pend), .instr_done_i(idone),
		.return_from_interrupt_done_i(rdone), .long_call_o(long_call), .vector_o(vec), .src_o(src), .ext_cfg_o(cfg),
		.active_hi_o(ahi), .active_lo_o(alo));
	core_model core (.clk_i(clk), .rst_i(rst), .long_call_i(long_call), .return_from_interrupt_req_i(rq), .gap_i(gap),
		.instr_done_o(idone), .return_from_interrupt_done_o(rdone));
	// instruction ends since the last return, captured at each call
	always @(posedge clk) begin
		if (rdone) nsr <= 0;
		else if (idone) nsr <= nsr + 1;
		if (long_call) at_call <= nsr;
	end
	task automatic chk(input logic [31:0] got, exp, input string m);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wrr(input logic [7:0] a, d); // one write cycle
		@(posedge clk); #1 addr = a; wd = d; wr = 1'b1;
		@(posedge clk); #1 wr = 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a, e, input logic h); // read, check next cycle
		@(posedge clk); #1 addr = a; rd = 1'b1;
		@(posedge clk); #1 rd = 1'b0;
		chk({hit, rdat}, {h, e}, "read");
	endtask
	task automatic fl(input logic [11:0] t, s, c); // trigger, set, clear pulses
		@(posedge clk); #1 trig = t; sset = s; sclr = c;
		@(posedge clk); #1 trig = '0; sset = '0; sclr = '0;
	endtask
	task automatic wcall(input logic [3:0] s); // bounded wait for a long_call
		int k;
		k = 0;
		while (k < 80 && long_call !== 1'b1) begin
			@(posedge clk); #1 k++;
		end
		chk(long_call, 1'b1, "no call");
		chk({src, vec}, {s, irq_ctrl_pkg::VEC_BASE + irq_ctrl_pkg::VEC_STEP * s}, "vector");
		@(posedge clk); #1;
	endtask
	task automatic nocall(input int n);
		repeat (n) begin
			@(posedge clk); #1 chk(long_call, 1'b0, "unexpected call");
		end
	endtask
	task automatic ret(input logic h, l); // return, then check levels in service
		int k;
		@(posedge clk); #1 rq = 1'b1;
		@(posedge clk); #1 rq = 1'b0;
		k = 0;
		while (k < 40 && rdone !== 1'b1) begin
			@(posedge clk); #1 k++;
		end
		chk(rdone, 1'b1, "no return");
		@(posedge clk); #1 chk({ahi, alo}, {h, l}, "levels after return");
	endtask
	task automatic stop_test;
		if (fails == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100us fails++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		// reset values, unmapped address, write and read back
		for (i = 0; i < 5; i++) rdr(regs[i], 8'h00, 1'b1);
		rdr(8'ha9, 8'h00, 1'b0);
		for (i = 0; i < 5; i++) wrr(regs[i], 8'h5a ^ 8'(i));
		for (i = 0; i < 5; i++) rdr(regs[i], 8'h5a ^ 8'(i), 1'b1);
		chk(cfg, 8'h58, "ext cfg");
		for (i = 0; i < 5; i++) wrr(regs[i], 8'h00);
		// flag set while disabled, then global off, then enabled
		fl(12'h004, '0, '0);
		chk(pend, 12'h004, "pending");
		nocall(20);
		wrr(8'ha8, 8'h04);
		nocall(20);
		wrr(8'ha8, 8'h84);
		wcall(4'd2);
		chk({pend, alo}, {12'h000, 1'b1}, "auto clear");
		ret(1'b0, 1'b0);
		// every source by software set, prompt and slow core
		wrr(8'ha8, 8'hbf);
		wrr(8'he6, 8'h3f);
		for (i = 0; i < 12; i++) begin
			gap = 4'(i / 2);
			fl('0, 12'h001 << i, '0);
			wcall(4'(i));
			fl('0, '0, 12'h001 << i);
			ret(1'b0, 1'b0);
		end
		// two at once: fixed order, then re-entry after return
		gap = 4'h2;
		fl('0, 12'h030, '0);
		wcall(4'd4);
		fl('0, '0, 12'h010);
		ret(1'b0, 1'b0);
		wcall(4'd5);
		chk(32'(at_call), 32'd1, "instr ends before re-entry");
		fl('0, '0, 12'h020);
		ret(1'b0, 1'b0);
		// high preempts low, nothing preempts high
		wrr(8'hb8, 8'h20);
		wrr(8'hf6, 8'h01);
		fl('0, 12'h010, '0);
		wcall(4'd4);
		fl('0, 12'h020, '0);
		wcall(4'd5);
		chk({ahi, alo}, 2'b11, "nested levels");
		fl('0, 12'h040, '0);
		nocall(30);
		fl('0, '0, 12'h020);
		ret(1'b0, 1'b1);
		wcall(4'd6);
		fl('0, '0, 12'h050);
		ret(1'b0, 1'b1);
		ret(1'b0, 1'b0);
		nocall(20);
		// global enable cleared, followed by multi-cycle instructions only
		gap = 4'h3;
		wrr(8'ha8, 8'h3f);
		fl('0, 12'h080, '0);
		nocall(20);
		rdr(8'ha8, 8'h3f, 1'b1);
		fl('0, '0, 12'h080);
		chk(pend, 12'h000, "flags left");
		stop_test;
	end
endmodule
`default_nettype wire
